// *** shared/tpcc_regs.svh ***
// Purpose: Register map, field positions and counts of the timer block
// Assumes: Byte addresses on a 32-bit APB, one register per word
// Notes:   Definitions only
`ifndef TPCC_REGS_SVH
`define TPCC_REGS_SVH
// Register byte offsets
`define TPCC_CLKCFG  8'h00
`define TPCC_TMOD    8'h04
`define TPCC_T0VAL   8'h08
`define TPCC_T1VAL   8'h0c
`define TPCC_T2CTL   8'h10
`define TPCC_T2VAL   8'h14
`define TPCC_T2REL   8'h18
`define TPCC_CAPCTL  8'h1c
`define TPCC_CAP0    8'h20
`define TPCC_CAP3    8'h2c
`define TPCC_CMP0    8'h30
`define TPCC_CMP2    8'h38
`define TPCC_FLAGS   8'h3c
`define TPCC_IRQEN   8'h40
`define TPCC_IRQPRI  8'h44
`define TPCC_SETEN   8'h48
`define TPCC_RSTEN   8'h4c
`define TPCC_PORT4   8'h50
// Clock config fields
`define TPCC_DIV_LO  0
`define TPCC_MULT    2
`define TPCC_T0SEL   3
// Timer 0/1 mode nibble fields
`define TPCC_GATE    2
`define TPCC_RUN     3
// Timer 2 control fields
`define TPCC_CRS     0
`define TPCC_T2RUN   1
`define TPCC_TXB     4
`define TPCC_RXB     5
`define TPCC_DIR_EN  6
// Flag field: compare flags sit above capture flags
`define TPCC_CMP_LSB 4
// Oscillator clocks per timer 0/1 tick
`define TPCC_OSC_12   12'd12
`define TPCC_OSC_1    12'd1
`define TPCC_OSC_2    12'd2
`define TPCC_OSC_4    12'd4
`define TPCC_OSC_3072 12'd3072
`define TPCC_OSC_1024 12'd1024
// Port 4 reset value and counter tops
`define TPCC_P4_RST  8'hff
`define TPCC_CNT_TOP 16'hffff
`define TPCC_T13_TOP 13'h1fff
`endif

// *** shared/tpcc_pkg.sv ***
// Purpose: Types shared by the timer block
// Assumes: Nothing
// Notes:   Counting modes of timers 0 and 1
package tpcc_pkg;
  typedef enum logic [1:0] {
    TPCC_M13, TPCC_M16, TPCC_M8R, TPCC_MSPLIT
  } tpcc_tmode_t;
endpackage

// *** logic/tpcc_top.sv ***
// Purpose: Timer 0/1 prescale, timer 2 with capture and compare, APB regs
// Assumes: All pins synchronous to clk_sys except the trigger, gate and direction pins
// Notes:   One wait state on every APB access
//
// How it works
// - Divider 00 gives 12, 1 or 2 clocks
// - Divider 10: 12/4; 11: 3072/1024; 01 reserved
// - Tick period ignores timer counting mode
// - Timers 0/1: 13, 16, reload, gated; split on timer 0 only, timer 1 holds
// - Timer 2 baud mode from select bits
// - Timer 2 reload, up/down, clock out
// - Four 16-bit capture registers
// - Trigger edge latches full timer 2 value
// - Capture works in any timer 2 mode
// - Two control bits per pin enable rising and falling capture
// - Rising-edge bit of each pin sets interrupt sense level
// - Triggers are four shared interrupt pins
// - Three 16-bit compare registers checked on each timer 2 step
// - Match sets flag, request only if enabled
// - Compare flags at bits 4 and up
// - Port pins 0-5 set/reset, 6-7 toggle
// - Match 0 sets, match 1 clears pins
// - Match 2 toggles pins 6 and 7
// - Disabled enable bit leaves pin alone
`timescale 1ns/10ps
`include "tpcc_regs.svh"
module tpcc_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic [3:0]  ext_irq2_capture_trig0,
  input  wire logic [1:0]  timer_gate_pin,
  input  wire logic        timer2_ext_trigger,
  // Port 4 and status outputs
  output logic      [7:0]  match_setreset_out0,
  output logic      [3:0]  ext_irq_active,
  output logic      [1:0]  timer_overflow,
  output logic             timer2_overflow,
  output logic             timer2_clk_out,
  output logic             timer2_baud_mode,
  output logic      [6:0]  irq_request,
  output logic      [6:0]  irq_prio
);
  import tpcc_pkg::*;

  // Oscillator clocks per timer tick, zero when reserved
  function automatic logic [11:0] osc_per_tick(input logic [1:0] dv,
                                               input logic mult,
                                               input logic sel);
    case (dv)
      2'b00:   return sel ? (mult ? `TPCC_OSC_1 : `TPCC_OSC_2)
                          : `TPCC_OSC_12;
      2'b10:   return sel ? `TPCC_OSC_4 : `TPCC_OSC_12;
      2'b11:   return sel ? `TPCC_OSC_1024 : `TPCC_OSC_3072;
      default: return 12'h000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [4:0]  clk_cfg, next_clk_cfg;          // Divider, mult, selects
  logic [7:0]  tmod, next_tmod;                // Timer 0/1 mode nibbles
  logic [6:0]  timer2_control_reg, next_t2ctl; // Timer 2 control
  logic [15:0] t2rel, next_t2rel;              // Timer 2 reload value
  logic [7:0]  capture_edge_control_reg, next_capctl;
  logic [15:0] cmp [3];                        // Compare registers
  logic [15:0] next_cmp [3];
  logic [6:0]  ext_irq_enable_reg, next_irqen;
  logic [6:0]  ext_irq_priority_reg, next_irqpri;
  logic [5:0]  match_set_enable_reg, next_seten;
  logic [7:0]  match_reset_toggle_enable_reg, next_rsten;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        acc, wr;                        // Access and write commit
  logic [15:0] tcnt [2];                       // Timer 0/1 counts
  logic        t_ovf [2];                      // Timer 0/1 overflow
  logic        tick [2];                       // Prescaled tick
  logic [15:0] t2, next_t2;                    // Timer 2 count
  logic        t2_step, next_t2_step;          // Timer 2 moved
  logic        next_t2_ovf, next_t2clk;
  logic [6:0]  timer2_irq_flags_reg, next_flags;
  logic [15:0] cap [4];                        // Capture registers
  logic [15:0] next_cap [4];
  logic [7:0]  next_p4;
  logic [3:0]  trig_s1, trig_s2, trig_d;       // Trigger synchroniser
  logic [1:0]  gate_s1, gate_s2;
  logic        dir_s1, dir_s2;                 // Count direction pin
  logic [3:0]  cap_ev;                         // Qualified trigger edges
  logic [2:0]  hit;                            // Compare matches

  assign acc = psel & penable & ~pready;
  assign wr  = psel & penable & pready & pwrite & ~pslverr;
  assign timer_overflow = {t_ovf[1], t_ovf[0]};

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // APB decode and configuration registers
  always_comb begin
    next_pready  = acc;
    next_pslverr = acc & ((paddr[1:0] != 2'b00) | (paddr > `TPCC_PORT4));
    next_prdata  = 32'h0000_0000;
    if (acc) begin
      // Read mux
      case (paddr)
        `TPCC_CLKCFG: next_prdata = {27'h0, clk_cfg};
        `TPCC_TMOD:   next_prdata = {24'h0, tmod};
        `TPCC_T0VAL:  next_prdata = {16'h0, tcnt[0]};
        `TPCC_T1VAL:  next_prdata = {16'h0, tcnt[1]};
        `TPCC_T2CTL:  next_prdata = {25'h0, timer2_control_reg};
        `TPCC_T2VAL:  next_prdata = {16'h0, t2};
        `TPCC_T2REL:  next_prdata = {16'h0, t2rel};
        `TPCC_CAPCTL: next_prdata = {24'h0, capture_edge_control_reg};
        `TPCC_FLAGS:  next_prdata = {25'h0, timer2_irq_flags_reg};
        `TPCC_IRQEN:  next_prdata = {25'h0, ext_irq_enable_reg};
        `TPCC_IRQPRI: next_prdata = {25'h0, ext_irq_priority_reg};
        `TPCC_SETEN:  next_prdata = {26'h0, match_set_enable_reg};
        `TPCC_RSTEN:  next_prdata = {24'h0, match_reset_toggle_enable_reg};
        `TPCC_PORT4:  next_prdata = {24'h0, match_setreset_out0};
        default: begin
          // Capture and compare windows
          if (paddr >= `TPCC_CAP0 && paddr <= `TPCC_CAP3)
            next_prdata = {16'h0, cap[paddr[3:2]]};
          else if (paddr >= `TPCC_CMP0 && paddr <= `TPCC_CMP2)
            next_prdata = {16'h0, cmp[paddr[3:2]]};
        end
      endcase
    end
    next_clk_cfg = clk_cfg;
    next_tmod    = tmod;
    next_t2ctl   = timer2_control_reg;
    next_t2rel   = t2rel;
    next_capctl  = capture_edge_control_reg;
    next_cmp     = cmp;
    next_irqen   = ext_irq_enable_reg;
    next_irqpri  = ext_irq_priority_reg;
    next_seten   = match_set_enable_reg;
    next_rsten   = match_reset_toggle_enable_reg;
    if (wr) begin
      // Write commit at the completing edge
      case (paddr)
        `TPCC_CLKCFG: next_clk_cfg = pwdata[4:0];
        `TPCC_TMOD:   next_tmod    = pwdata[7:0];
        `TPCC_T2CTL:  next_t2ctl   = pwdata[6:0];
        `TPCC_T2REL:  next_t2rel   = pwdata[15:0];
        `TPCC_CAPCTL: next_capctl  = pwdata[7:0];
        `TPCC_IRQEN:  next_irqen   = pwdata[6:0];
        `TPCC_IRQPRI: next_irqpri  = pwdata[6:0];
        `TPCC_SETEN:  next_seten   = pwdata[5:0];
        `TPCC_RSTEN:  next_rsten   = pwdata[7:0];
        default: begin
          if (paddr >= `TPCC_CMP0 && paddr <= `TPCC_CMP2)
            next_cmp[paddr[3:2]] = pwdata[15:0];
        end
      endcase
    end
  end

  // Configuration and bus registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      clk_cfg <= 5'h00;
      tmod    <= 8'h00;
      timer2_control_reg <= 7'h00;
      t2rel   <= 16'h0000;
      capture_edge_control_reg <= 8'h00;
      cmp     <= '{default: 16'h0000};
      ext_irq_enable_reg   <= 7'h00;
      ext_irq_priority_reg <= 7'h00;
      match_set_enable_reg <= 6'h00;
      match_reset_toggle_enable_reg <= 8'h00;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
      clk_cfg <= next_clk_cfg;
      tmod    <= next_tmod;
      timer2_control_reg <= next_t2ctl;
      t2rel   <= next_t2rel;
      capture_edge_control_reg <= next_capctl;
      cmp     <= next_cmp;
      ext_irq_enable_reg   <= next_irqen;
      ext_irq_priority_reg <= next_irqpri;
      match_set_enable_reg <= next_seten;
      match_reset_toggle_enable_reg <= next_rsten;
    end
  end

  sequence apb_access_s;
    psel && penable && !pready;
  endsequence
  sequence apb_done_s;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (apb_access_s |=> apb_done_s)
    else $error("APB answer not one cycle after access");

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      trig_s1 <= 4'h0;
      trig_s2 <= 4'h0;
      trig_d  <= 4'h0;
      gate_s1 <= 2'h0;
      gate_s2 <= 2'h0;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
    end else begin
      trig_s1 <= ext_irq2_capture_trig0;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
      gate_s1 <= timer_gate_pin;
      gate_s2 <= gate_s1;
      dir_s1  <= timer2_ext_trigger;
      dir_s2  <= dir_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers 0 and 1 with prescaler
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic [11:0] pre, next_pre, period;
    logic        next_tick, next_ovf, en;
    logic [15:0] next_cnt;
    logic [3:0]  md;
    tpcc_tmode_t mode;
    assign md     = tmod[i*4 +: 4];
    assign mode   = tpcc_tmode_t'(md[1:0]);
    // Period uses only clock settings, never the mode
    assign period = osc_per_tick(clk_cfg[`TPCC_DIV_LO +: 2],
                                 clk_cfg[`TPCC_MULT],
                                 clk_cfg[`TPCC_T0SEL + i]);
    assign en = tick[i] & md[`TPCC_RUN] &
                (~md[`TPCC_GATE] | gate_s2[i]);
    always_comb begin
      next_pre  = pre + 12'd1;
      next_tick = 1'b0;
      next_ovf  = 1'b0;
      next_cnt  = tcnt[i];
      // Prescaler, stopped on reserved divider
      if (period == 12'h000)
        next_pre = 12'h000;
      else if (pre >= period - 12'd1) begin
        next_pre  = 12'h000;
        next_tick = 1'b1;
      end
      if (en) begin
        case (mode)
          TPCC_M13: begin
            next_cnt = {3'h0, tcnt[i][12:0] + 13'd1};
            next_ovf = tcnt[i][12:0] == `TPCC_T13_TOP;
          end
          TPCC_M16: begin
            next_cnt = tcnt[i] + 16'd1;
            next_ovf = tcnt[i] == `TPCC_CNT_TOP;
          end
          TPCC_M8R: begin
            next_ovf = tcnt[i][7:0] == 8'hff;
            next_cnt[7:0] = next_ovf ? tcnt[i][15:8]
                                     : tcnt[i][7:0] + 8'd1;
          end
          default: begin
            // Split halves on timer 0; timer 1 holds
            if (i == 0) begin
              next_cnt = {tcnt[i][15:8] + 8'd1, tcnt[i][7:0] + 8'd1};
              next_ovf = tcnt[i][7:0] == 8'hff;
            end
          end
        endcase
      end
      if (wr && paddr == `TPCC_T0VAL + 8'(4 * i))
        next_cnt = pwdata[15:0];
    end
    // Timer state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        pre     <= 12'h000;
        tick[i] <= 1'b0;
        tcnt[i] <= 16'h0000;
        t_ovf[i] <= 1'b0;
      end else begin
        pre     <= next_pre;
        tick[i] <= next_tick;
        tcnt[i] <= next_cnt;
        t_ovf[i] <= next_ovf;
      end
    end
    // Cycles since last tick; zero until a tick after a setup change
    logic [11:0] gap;
    logic [4:0]  cfg_d;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        gap   <= 12'h000;
        cfg_d <= 5'h00;
      end else begin
        cfg_d <= clk_cfg;
        // First tick after a change may come early; do not time it
        if (clk_cfg != cfg_d || (gap == 12'h000 && !tick[i]))
          gap <= 12'h000;
        else
          gap <= tick[i] ? 12'd1 : gap + 12'd1;
      end
    end
    tick_period_a: assert property (
      tick[i] && $stable(clk_cfg) && $past(tick[i], 1) == 1'b0 &&
      gap != 12'h000 && $past(gap) != 12'h000 |-> gap == period)
      else $error("Timer tick period wrong");
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer 2, capture, compare, flags and port 4
  always_comb begin
    next_t2      = t2;
    next_t2_step = 1'b0;
    next_t2_ovf  = 1'b0;
    next_t2clk   = timer2_clk_out;
    if (timer2_control_reg[`TPCC_T2RUN]) begin
      next_t2_step = 1'b1;
      if (!timer2_control_reg[`TPCC_DIR_EN] || dir_s2) begin
        // Up count; reload only in reload mode
        next_t2_ovf = t2 == `TPCC_CNT_TOP;
        next_t2 = next_t2_ovf ? (timer2_control_reg[`TPCC_CRS] ?
                  16'h0000 : t2rel) : t2 + 16'd1;
      end else begin
        // Down count under direction enable
        next_t2_ovf = t2 == t2rel;
        next_t2 = next_t2_ovf ? `TPCC_CNT_TOP : t2 - 16'd1;
      end
      if (next_t2_ovf)
        next_t2clk = ~timer2_clk_out;
    end
    if (wr && paddr == `TPCC_T2VAL) begin
      next_t2      = pwdata[15:0];
      next_t2_step = 1'b0;
    end
    // Trigger edges, per-pin polarity
    for (int k = 0; k < 4; k++) begin
      cap_ev[k] = (trig_s2[k] & ~trig_d[k] &
                   capture_edge_control_reg[2*k]) |
                  (~trig_s2[k] & trig_d[k] &
                   capture_edge_control_reg[2*k+1]);
      next_cap[k] = cap_ev[k] ? t2 : cap[k];
    end
    // One check per timer step
    for (int k = 0; k < 3; k++)
      hit[k] = t2_step & (t2 == cmp[k]);
    // Set wins over write-one clear
    next_flags = timer2_irq_flags_reg;
    if (wr && paddr == `TPCC_FLAGS)
      next_flags = next_flags & ~pwdata[6:0];
    next_flags = next_flags | {hit, cap_ev};
    // Port 4: write, then toggle, clear, set
    next_p4 = match_setreset_out0;
    if (wr && paddr == `TPCC_PORT4)
      next_p4 = pwdata[7:0];
    if (hit[2])
      next_p4[7:6] = next_p4[7:6] ^
                     match_reset_toggle_enable_reg[7:6];
    if (hit[1])
      next_p4[5:0] = next_p4[5:0] &
                     ~match_reset_toggle_enable_reg[5:0];
    if (hit[0])
      next_p4[5:0] = next_p4[5:0] | match_set_enable_reg;
  end

  // Timer 2 group state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      t2 <= 16'h0000;
      t2_step <= 1'b0;
      timer2_overflow <= 1'b0;
      timer2_clk_out  <= 1'b0;
      timer2_baud_mode <= 1'b0;
      timer2_irq_flags_reg <= 7'h00;
      cap <= '{default: 16'h0000};
      match_setreset_out0 <= `TPCC_P4_RST;
      ext_irq_active <= 4'h0;
      irq_request <= 7'h00;
      irq_prio <= 7'h00;
    end else begin
      t2 <= next_t2;
      t2_step <= next_t2_step;
      timer2_overflow <= next_t2_ovf;
      timer2_clk_out  <= next_t2clk;
      timer2_baud_mode <= ~timer2_control_reg[`TPCC_CRS] &
        (timer2_control_reg[`TPCC_RXB] |
         timer2_control_reg[`TPCC_TXB]);
      timer2_irq_flags_reg <= next_flags;
      cap <= next_cap;
      match_setreset_out0 <= next_p4;
      for (int k = 0; k < 4; k++)
        ext_irq_active[k] <= capture_edge_control_reg[2*k] ?
                             trig_s2[k] : ~trig_s2[k];
      irq_request <= timer2_irq_flags_reg & ext_irq_enable_reg;
      irq_prio <= ext_irq_priority_reg;
    end
  end

  capture_latch_a: assert property (
    $rose(ext_irq2_capture_trig0[0]) && capture_edge_control_reg[0]
    ##1 capture_edge_control_reg[0] |=> ##1 cap[0] == $past(t2))
    else $error("Capture 0 did not latch timer 2");
  match_flag_a: assert property (
    t2_step && t2 == cmp[0] |=> timer2_irq_flags_reg[`TPCC_CMP_LSB])
    else $error("Compare 0 flag not set");
  once_per_step_a: assert property (
    $rose(timer2_irq_flags_reg[`TPCC_CMP_LSB]) |->
    $past(t2_step) && $past(t2) == $past(cmp[0]))
    else $error("Compare 0 flag set without a step match");
  irq_gate_a: assert property (
    timer2_irq_flags_reg[5] && !ext_irq_enable_reg[5] |=> !irq_request[5])
    else $error("Compare 1 request without enable");
  flag_hold_a: assert property (
    timer2_irq_flags_reg[4] && !(wr && paddr == `TPCC_FLAGS) |=>
    timer2_irq_flags_reg[4])
    else $error("Compare flag cleared by hardware");
  port_set_a: assert property (
    hit[0] && match_set_enable_reg[0] |=> match_setreset_out0[0])
    else $error("Port pin 0 not set on match 0");
  port_toggle_a: assert property (
    hit[2] && match_reset_toggle_enable_reg[6] &&
    !(wr && paddr == `TPCC_PORT4) |=>
    match_setreset_out0[6] != $past(match_setreset_out0[6]))
    else $error("Port pin 6 not toggled on match 2");
  port_keep_a: assert property (
    !match_set_enable_reg[1] && !match_reset_toggle_enable_reg[1] &&
    !(wr && paddr == `TPCC_PORT4) |=> $stable(match_setreset_out0[1]))
    else $error("Disabled port pin changed");
  baud_mode_a: assert property (
    !timer2_control_reg[0] && timer2_control_reg[`TPCC_TXB] |=>
    timer2_baud_mode)
    else $error("Baud mode not shown");
endmodule

// *** verif/tpcc_pins.sv ***
// Purpose: Far-side model driving the four capture trigger pins
// Assumes: Bench sets the wanted levels just after a clock edge
// Notes:   Slow mode delays every change by three extra cycles
`timescale 1ns/10ps
module tpcc_pins (
  // Clock and commands
  input  wire logic       clk_sys,
  input  wire logic       slow,
  input  wire logic [3:0] want_trig,
  // Pins toward the block
  output logic      [3:0] ext_irq2_capture_trig0
);
  logic [3:0] dly [3] = '{default: 4'h0};  // Delay line for slow mode

  initial ext_irq2_capture_trig0 = 4'h0;   // Idle low from time zero
  ////////////////////////////////////////////////////////////////////
  // Pins change only after an edge, promptly or late
  always @(posedge clk_sys) begin
    dly[0] <= want_trig;
    dly[1] <= dly[0];
    dly[2] <= dly[1];
    ext_irq2_capture_trig0 <= slow ? dly[2] : want_trig;
  end
endmodule

// *** verif/tb_timer_prescale_capture_compare.sv ***
// Purpose: Self-checking bench for the timer, capture and compare block
// Assumes: APB answers after one wait state; timer 2 steps every clock
// Notes:   Tick rates are counted over exact windows of clock cycles
`timescale 1ns/10ps
`include "tpcc_regs.svh"
module tb_timer_prescale_capture_compare;
  ////////////////////////////////////////////////////////////////////
  // Clock, reset and APB
  logic        clk_sys  = 1'h0;
  logic        sys_rst  = 1'h1;
  logic [7:0]  paddr    = 8'h00;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Pins and outputs
  logic [3:0]  want     = 4'h0;  // Wanted trigger levels
  logic        slow     = 1'h0;  // Partner answers late
  logic [3:0]  trig;
  logic [1:0]  gate     = 2'h0;
  logic        dir      = 1'h0;  // Timer 2 count direction
  logic [7:0]  p4;
  logic [3:0]  eia;
  logic [6:0]  irq_req;
  logic [6:0]  prio;
  logic        baud;
  logic [1:0]  tovf;             // Timer 0/1 overflow pulses
  logic        t2ovf;            // Timer 2 overflow pulse
  logic        t2clk;            // Timer 2 clock output
  // Bench state
  int          failures = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          n0       = 0;     // Pulse counts per overflow output
  int          n1       = 0;
  int          n2       = 0;
  int          w;
  logic        serr;             // Last slave error
  logic [31:0] q;                // Last read data
  logic [15:0] cv;               // Expected capture
  logic [7:0]  a;
  logic [7:0]  cf [10] = '{8'h04, 8'h0c, 8'h00, 8'h08, 8'h02, 8'h0a,
                           8'h03, 8'h0b, 8'h01, 8'h09};
  int          per [10] = '{12, 1, 12, 2, 12, 4, 3072, 1024, 0, 0};
  logic [7:0]  bc [5] = '{8'h20, 8'h21, 8'h10, 8'h00, 8'h30};
  logic [4:0]  bx = 5'h15;       // Expected baud mode per entry
  logic [3:0]  ex = 4'h9;        // Expected sense per pin step

  tpcc_pins PINS (.clk_sys(clk_sys), .slow(slow), .want_trig(want),
    .ext_irq2_capture_trig0(trig));
  tpcc_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq2_capture_trig0(trig), .timer_gate_pin(gate),
    .timer2_ext_trigger(dir), .match_setreset_out0(p4),
    .ext_irq_active(eia), .timer_overflow(tovf),
    .timer2_overflow(t2ovf), .timer2_clk_out(t2clk),
    .timer2_baud_mode(baud),
    .irq_request(irq_req), .irq_prio(prio));

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  // Count overflow pulses once out of reset
  always @(posedge clk_sys)
    if (!sys_rst) begin
      n0 <= n0 + int'(tovf[0]);
      n1 <= n1 + int'(tovf[1]);
      n2 <= n2 + int'(t2ovf);
    end
  ////////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] ad, input logic wd,
                     input logic [31:0] d);
    @(posedge clk_sys);
    paddr <= ad;
    pwrite <= wd;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    q = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'h1, d);
  endtask
  // Compare any result, zero extended
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    apb(ad, 1'h0, 32'h0);
    chk(q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Counter change between two reads exactly n cycles apart
  task automatic span(input logic [7:0] ad, input int n,
                      input logic [15:0] d);
    logic [15:0] q0;
    int          c0;
    c0 = cyc;
    apb(ad, 1'h0, 32'h0);
    q0 = q[15:0];
    while (cyc < c0 + n) @(posedge clk_sys);
    apb(ad, 1'h0, 32'h0);
    q0 = q[15:0] - q0;
    chk({16'h0, q0}, {16'h0, d});
  endtask
  task automatic conclude;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Watchdog: cut a hang short
  initial begin
    idle(80000);
    failures++;
    conclude();
  end
  // Test sequence
  initial begin
    idle(4);
    sys_rst <= 1'h0;
    chk({24'h0, p4}, 32'hff);
    rc(`TPCC_PORT4, 32'hff);
    apb(8'h54, 1'h0, 32'h0);
    chk({q[30:0], serr}, 32'h1);
    apb(8'h02, 1'h0, 32'h0);
    chk({q[30:0], serr}, 32'h1);
    $display("test reset done");
    // Counting mode and gate leave the tick rate alone
    wr(`TPCC_CLKCFG, 32'h0a);
    wr(`TPCC_TMOD, 32'h08);
    wr(`TPCC_T0VAL, 32'h0);
    span(`TPCC_T0VAL, 24, 16'h6);
    wr(`TPCC_TMOD, 32'h0d);
    span(`TPCC_T0VAL, 24, 16'h0);
    gate <= 2'h1;
    idle(4);
    span(`TPCC_T0VAL, 24, 16'h6);
    wr(`TPCC_TMOD, 32'h09);
    for (int i = 0; i < 10; i++) begin
      wr(`TPCC_CLKCFG, {24'h0, cf[i]});
      idle(4100);
      w = (per[i] == 0) ? 48 : (per[i] < 24) ? 24 : per[i];
      span(`TPCC_T0VAL, w, 16'((per[i] == 0) ? 0 : w / per[i]));
    end
    $display("test prescale done");
    // Each pin: rise and fall under both edge choices
    for (int k = 0; k < 4; k++) begin
      a = `TPCC_CAP0 + 8'(4 * k);
      cv = {4'(k), 12'h5a1};
      slow <= k[0];
      wr(`TPCC_CAPCTL, 32'h55);
      for (int s = 0; s < 4; s++) begin
        if (s == 2)
          wr(`TPCC_CAPCTL, 32'haa);
        if (s == 3)
          cv = ~cv;
        wr(`TPCC_T2VAL, (s == 0 || s == 3) ? {16'h0, cv} : 32'h1);
        want <= want ^ (4'h1 << k);
        idle(12);
        rc(a, {16'h0, cv});
        chk({31'h0, eia[k]}, {31'h0, ex[s]});
        if (s == 0)
          rc(`TPCC_FLAGS, 32'(1 << k));
      end
      wr(`TPCC_FLAGS, 32'hf);
      rc(`TPCC_FLAGS, 32'h0);
    end
    wr(`TPCC_CAP3, 32'h1234);
    rc(`TPCC_CAP3, {16'h0, cv});
    $display("test capture done");
    // Timer 2 up and down under the direction pin
    wr(`TPCC_T2VAL, 32'h100);
    wr(`TPCC_T2CTL, 32'h43);
    span(`TPCC_T2VAL, 30, 16'hffe2);
    dir <= 1'h1;
    idle(4);
    span(`TPCC_T2VAL, 30, 16'h1e);
    $display("test updown done");
    // Three compares: set, clear, toggle
    wr(`TPCC_T2CTL, 32'h0);
    wr(`TPCC_PORT4, 32'h0);
    wr(`TPCC_CMP0, 32'h28);
    wr(`TPCC_CMP0 + 8'h04, 32'h50);
    wr(`TPCC_CMP2, 32'h3c);
    wr(`TPCC_SETEN, 32'h15);
    wr(`TPCC_RSTEN, 32'h41);
    wr(`TPCC_IRQEN, 32'h10);
    wr(`TPCC_IRQPRI, 32'h30);
    wr(`TPCC_FLAGS, 32'h7f);
    wr(`TPCC_T2VAL, 32'h0);
    wr(`TPCC_T2CTL, 32'h03);
    idle(120);
    chk({24'h0, p4}, 32'h54);
    chk({25'h0, prio}, 32'h30);
    chk({25'h0, irq_req}, 32'h10);
    rc(`TPCC_FLAGS, 32'h70);
    wr(`TPCC_T2CTL, 32'h0);
    wr(`TPCC_FLAGS, 32'h70);
    wr(`TPCC_T2VAL, 32'h28);
    idle(8);
    rc(`TPCC_FLAGS, 32'h0);
    chk({24'h0, p4}, 32'h54);
    $display("test compare done");
    // Overflow pulses: 8-bit reload, timer 2 wrap; then split half counts
    wr(`TPCC_T0VAL, 32'hfc);
    wr(`TPCC_T1VAL, 32'hfc);
    wr(`TPCC_TMOD, 32'haa);
    wr(`TPCC_T2VAL, 32'hfff0);
    wr(`TPCC_T2CTL, 32'h03);
    wr(`TPCC_CLKCFG, 32'h1c);
    idle(40);
    chk(n0, 32'h1);
    chk(n1, 32'h1);
    chk(n2, 32'h1);
    chk({31'h0, t2clk}, 32'h1);
    wr(`TPCC_TMOD, 32'h0b);
    wr(`TPCC_T0VAL, 32'h0);
    span(`TPCC_T0VAL, 24, 16'h1818);
    $display("test overflow done");
    // Baud mode from the timer 2 select bits
    for (int i = 0; i < 5; i++) begin
      wr(`TPCC_T2CTL, {24'h0, bc[i]});
      idle(3);
      chk({31'h0, baud}, {31'h0, bx[i]});
    end
    $display("test baud done");
    conclude();
  end
endmodule
